// ===== hdl/cdr_pkg.sv
package cdr_pkg;
   // bus register byte offsets
   localparam logic [7:0] CDR_OFS_CMD = 8'h00;
   localparam logic [7:0] CDR_OFS_STATUS = 8'h04;
   localparam logic [7:0] CDR_OFS_RDDATA = 8'h08;
   localparam logic [7:0] CDR_OFS_MODE = 8'h0C;
   // command word fields
   localparam int CDR_CMD_RD_BIT = 9;
   localparam int CDR_CMD_RS_BIT = 8;
   // status fields
   localparam int CDR_ST_BUSY_BIT = 7;
   localparam int CDR_ST_PEND_BIT = 8;
   localparam int CDR_ST_RDV_BIT = 9;
   // mode fields
   localparam int CDR_MD_INC_BIT = 0;
   localparam int CDR_MD_SHIFT_BIT = 1;
   localparam int CDR_MD_TWO_BIT = 2;
   localparam int CDR_MD_GLYPH_BIT = 3;
   localparam int CDR_MD_OFS_LSB = 8;
   // reset values
   localparam logic CDR_RST_INC = 1'b1;
   localparam logic CDR_RST_SHIFT = 1'b0;
   localparam logic CDR_RST_TWO = 1'b0;
   localparam logic [6:0] CDR_RST_AC = 7'h00;
   localparam logic [7:0] CDR_RST_RDBUF = 8'h00;
   // address ranges
   localparam logic [6:0] CDR_ONE_LAST = 7'h4F;
   localparam logic [6:0] CDR_L1_FIRST = 7'h00;
   localparam logic [6:0] CDR_L1_LAST = 7'h27;
   localparam logic [6:0] CDR_L2_FIRST = 7'h40;
   localparam logic [6:0] CDR_L2_LAST = 7'h67;
   // sizes
   localparam int CDR_DDR_DEPTH = 128;
   localparam int CDR_CGR_DEPTH = 64;
   localparam int CDR_FIFO_DEPTH = 16;
   // timing
   localparam int CDR_CLK_NS = 40;
   localparam int CDR_INSTR_NS = 39000;
   localparam int CDR_DATA_NS = 43000;
   localparam int CDR_INSTR_CYC = (CDR_INSTR_NS + CDR_CLK_NS - 1) / CDR_CLK_NS;
   localparam int CDR_DATA_CYC = (CDR_DATA_NS + CDR_CLK_NS - 1) / CDR_CLK_NS;
   localparam int CDR_CNT_W = 11;

   typedef struct packed {
      logic read_dir;
      logic reg_select;
      logic [7:0] bus_byte;
   } cdr_cmd_t;

   typedef struct packed {
      logic inc;
      logic auto_display_shift;
      logic two_line;
      logic glyph_sel;
   } cdr_mode_t;

   typedef enum logic [4:0] {
      CDR_ST_IDLE = 5'b00001,
      CDR_ST_EXEC = 5'b00010,
      CDR_ST_FILL = 5'b00100,
      CDR_ST_LOAD = 5'b01000,
      CDR_ST_WAIT = 5'b10000
   } cdr_state_t;
endpackage

// ===== hdl/cdr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cdr_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data = mem[rd_ptr_r];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         if (push & !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop & !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////

module cdr_ram #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 128
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

// ===== hdl/cdr_top.sv
// Functional notes
// RL1 - instruction byte with top bit set loads address counter, selects display RAM
// RL2 - one-line mode display addresses run 00H through 4FH
// RL3 - two-line mode: line one 00H-27H, line two 40H-67H
// RL4 - status read returns busy on top bit, address counter below
// RL5 - while busy, no new instruction is taken
// RL6 - host polls busy clear before each write
// RL7 - one address counter serves both RAMs, set by last instruction
// RL8 - data write stores full byte at address counter
// RL9 - last address-set kind picks glyph or display RAM
// RL10 - after data write, step counter by entry mode, apply display shift
// RL11 - data read returns a RAM byte
// RL12 - after data read, step counter, never shift display
// RL13 - first read without address set is stale; second onward valid
// RL14 - cursor shift primes read path like a display address set; code primes it only on a left cursor shift (bus_byte[2] clear)
// RL15 - after a write, next read is stale until address set or cursor shift; code primes it only on a left cursor shift (bus_byte[2] clear)
// RL16 - direction bit set increments, clear decrements, both RAMs
// RL17 - line-count bit: 0 single line, 1 two lines
// RL18 - shift bit: write shifts display left on increment, right on decrement
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cdr_top
   import cdr_pkg::*;
#(
   parameter int FIFO_DEPTH = cdr_pkg::CDR_FIFO_DEPTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   import cdr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // address stepping within the valid ranges
   function automatic logic [6:0] step_addr(input logic [6:0] ac, input cdr_mode_t md);
      logic [6:0] nx;
      nx = ac;
      if (md.glyph_sel) begin
         nx = md.inc ? {1'b0, ac[5:0] + 6'h01} : {1'b0, ac[5:0] - 6'h01};
      end else if (!md.two_line) begin
         if (md.inc) begin
            nx = (ac >= CDR_ONE_LAST) ? CDR_L1_FIRST : ac + 7'h01; // RL2
         end else begin
            nx = (ac == CDR_L1_FIRST || ac > CDR_ONE_LAST) ? CDR_ONE_LAST : ac - 7'h01; // RL2
         end
      end else if (md.inc) begin
         if (ac == CDR_L1_LAST) begin
            nx = CDR_L2_FIRST; // RL3
         end else if (ac >= CDR_L2_LAST) begin
            nx = CDR_L1_FIRST; // RL3
         end else begin
            nx = ac + 7'h01;
         end
      end else begin
         if (ac == CDR_L2_FIRST) begin
            nx = CDR_L1_LAST; // RL3
         end else if (ac == CDR_L1_FIRST || ac > CDR_L2_LAST) begin
            nx = CDR_L2_LAST; // RL3
         end else begin
            nx = ac - 7'h01;
         end
      end
      return nx;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   cdr_state_t state_r;
   cdr_mode_t mode_r;
   cdr_cmd_t cmd_r;
   logic [6:0] ac_r;
   logic [6:0] shift_ofs_r;
   logic [7:0] rdbuf_r;
   logic [7:0] result_r;
   logic rd_valid_r;
   logic [CDR_CNT_W-1:0] busy_cnt_r;
   logic busy_indicator;

   // bus side
   logic dph_cmd_r;
   logic dph_rd_r;
   logic [7:0] dph_ofs_r;
   logic hreadyout_r;
   logic [31:0] hrdata_r;
   logic addr_ok;
   logic [7:0] ofs;
   logic rddata_read;

   // fifo
   cdr_cmd_t fifo_in;
   cdr_cmd_t fifo_out;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_pop;

   // ram
   logic ddr_we;
   logic cgr_we;
   logic [7:0] ddr_rdata;
   logic [7:0] cgr_rdata;
   logic [7:0] ram_rdata;

   assign busy_indicator = !state_r[0];
   assign ofs = haddr[7:0];
   assign addr_ok = hsel & htrans[1] & hready;
   assign fifo_in = cdr_cmd_t'(hwdata[9:0]);
   assign fifo_pop = state_r[0] & fifo_out_valid; // RL5
   assign ram_rdata = mode_r.glyph_sel ? cgr_rdata : ddr_rdata; // RL9
   assign rddata_read = addr_ok & !hwrite & (ofs == CDR_OFS_RDDATA);
   assign hreadyout = hreadyout_r;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_cmd_r <= 1'b0;
         dph_rd_r <= 1'b0;
         dph_ofs_r <= 8'h00;
      end else if (hreadyout_r) begin
         dph_cmd_r <= addr_ok & hwrite & (ofs == CDR_OFS_CMD);
         dph_rd_r <= addr_ok & !hwrite;
         dph_ofs_r <= ofs;
      end else if (fifo_in_ready) begin
         dph_cmd_r <= 1'b0;
      end
   end

   // command writes wait until the fifo takes the word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_r <= 1'b1;
      end else if (hreadyout_r) begin
         hreadyout_r <= !(addr_ok & hwrite & (ofs == CDR_OFS_CMD));
      end else begin
         hreadyout_r <= fifo_in_ready;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (addr_ok & !hwrite) begin
         hrdata_r <= 32'h0000_0000;
         case (ofs)
            CDR_OFS_STATUS: begin
               hrdata_r[CDR_ST_BUSY_BIT] <= busy_indicator; // RL4
               hrdata_r[6:0] <= ac_r; // RL4
               hrdata_r[CDR_ST_PEND_BIT] <= fifo_out_valid;
               hrdata_r[CDR_ST_RDV_BIT] <= rd_valid_r;
            end
            CDR_OFS_RDDATA: begin
               hrdata_r[7:0] <= result_r;
               hrdata_r[CDR_ST_PEND_BIT] <= rd_valid_r;
            end
            CDR_OFS_MODE: begin
               hrdata_r[CDR_MD_INC_BIT] <= mode_r.inc;
               hrdata_r[CDR_MD_SHIFT_BIT] <= mode_r.auto_display_shift;
               hrdata_r[CDR_MD_TWO_BIT] <= mode_r.two_line;
               hrdata_r[CDR_MD_GLYPH_BIT] <= mode_r.glyph_sel;
               hrdata_r[CDR_MD_OFS_LSB +: 7] <= shift_ofs_r;
            end
            default: begin
               hrdata_r <= 32'h0000_0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command queue
   cdr_fifo #(
      .WIDTH($bits(cdr_cmd_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .in_valid(dph_cmd_r & !hreadyout_r),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // character and glyph memories
   assign ddr_we = state_r[1] & cmd_r.reg_select & !cmd_r.read_dir & !mode_r.glyph_sel;
   assign cgr_we = state_r[1] & cmd_r.reg_select & !cmd_r.read_dir & mode_r.glyph_sel;

   cdr_ram #(
      .WIDTH(8),
      .DEPTH(CDR_DDR_DEPTH)
   ) u_display_char_ram (
      .clk(hclk),
      .we(ddr_we), // RL8
      .addr(ac_r), // RL7
      .wdata(cmd_r.bus_byte),
      .rdata(ddr_rdata)
   );

   cdr_ram #(
      .WIDTH(8),
      .DEPTH(CDR_CGR_DEPTH)
   ) u_glyph_pattern_ram (
      .clk(hclk),
      .we(cgr_we), // RL8
      .addr(ac_r[5:0]), // RL7
      .wdata(cmd_r.bus_byte),
      .rdata(cgr_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // interpreter sequencing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= CDR_ST_IDLE;
         cmd_r <= '0;
         busy_cnt_r <= '0;
      end else begin
         case (state_r)
            CDR_ST_IDLE: begin
               if (fifo_out_valid) begin
                  cmd_r <= fifo_out; // RL5
                  state_r <= CDR_ST_EXEC;
               end
            end
            CDR_ST_EXEC: begin
               if (cmd_r.reg_select) begin
                  busy_cnt_r <= CDR_CNT_W'(CDR_DATA_CYC);
                  state_r <= cmd_r.read_dir ? CDR_ST_FILL : CDR_ST_WAIT;
               end else if (cmd_r.read_dir) begin
                  state_r <= CDR_ST_IDLE;
               end else begin
                  busy_cnt_r <= CDR_CNT_W'(CDR_INSTR_CYC);
                  if (cmd_r.bus_byte[7:6] != 2'b00 ||
                      cmd_r.bus_byte[7:2] == 6'b000100) begin
                     state_r <= CDR_ST_FILL; // RL14
                  end else begin
                     state_r <= CDR_ST_WAIT;
                  end
               end
            end
            CDR_ST_FILL: begin
               busy_cnt_r <= busy_cnt_r - 1'b1;
               state_r <= CDR_ST_LOAD;
            end
            CDR_ST_LOAD: begin
               busy_cnt_r <= busy_cnt_r - 1'b1;
               state_r <= CDR_ST_WAIT;
            end
            CDR_ST_WAIT: begin
               busy_cnt_r <= busy_cnt_r - 1'b1;
               if (busy_cnt_r <= CDR_CNT_W'(2)) begin
                  state_r <= CDR_ST_IDLE; // RL5
               end
            end
            default: begin
               state_r <= CDR_ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // address counter and mode
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ac_r <= CDR_RST_AC;
         mode_r <= '{CDR_RST_INC, CDR_RST_SHIFT, CDR_RST_TWO, 1'b0};
      end else if (state_r[1]) begin
         if (cmd_r.reg_select) begin
            ac_r <= step_addr(ac_r, mode_r); // RL10 RL12 RL16
         end else if (!cmd_r.read_dir) begin
            if (cmd_r.bus_byte[7]) begin
               ac_r <= cmd_r.bus_byte[6:0]; // RL1 RL7
               mode_r.glyph_sel <= 1'b0; // RL1 RL9
            end else if (cmd_r.bus_byte[7:6] == 2'b01) begin
               ac_r <= {1'b0, cmd_r.bus_byte[5:0]}; // RL7
               mode_r.glyph_sel <= 1'b1; // RL9
            end else if (cmd_r.bus_byte[7:5] == 3'b001) begin
               mode_r.two_line <= cmd_r.bus_byte[3]; // RL17
            end else if (cmd_r.bus_byte[7:3] == 5'b00010) begin
               ac_r <= step_addr(ac_r, '{cmd_r.bus_byte[2], 1'b0, mode_r.two_line,
                                          1'b0}); // RL14
               mode_r.glyph_sel <= 1'b0; // RL14
            end else if (cmd_r.bus_byte[7:2] == 6'b000001) begin
               mode_r.inc <= cmd_r.bus_byte[1]; // RL16
               mode_r.auto_display_shift <= cmd_r.bus_byte[0]; // RL18
            end
         end
      end
   end

   // display shift position
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         shift_ofs_r <= 7'h00;
      end else if (state_r[1]) begin
         if (ddr_we & mode_r.auto_display_shift) begin
            shift_ofs_r <= mode_r.inc ? shift_ofs_r + 7'h01 : shift_ofs_r - 7'h01; // RL10 RL18
         end else if (!cmd_r.reg_select & !cmd_r.read_dir &
                      cmd_r.bus_byte[7:3] == 5'b00011) begin
            shift_ofs_r <= cmd_r.bus_byte[2] ? shift_ofs_r - 7'h01 : shift_ofs_r + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: buffer refilled only on address set, left cursor shift or data read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdbuf_r <= CDR_RST_RDBUF; // RL13
      end else if (state_r[3]) begin
         rdbuf_r <= ram_rdata; // RL13 RL14 RL15
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         result_r <= 8'h00;
      end else if (state_r[1] & cmd_r.read_dir) begin
         if (cmd_r.reg_select) begin
            result_r <= rdbuf_r; // RL11 RL13
         end else begin
            result_r <= {1'b0, ac_r}; // RL4
         end
      end
   end

   // set wins over the clear by software read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_valid_r <= 1'b0;
      end else if (state_r[1] & cmd_r.read_dir) begin
         rd_valid_r <= 1'b1;
      end else if (rddata_read) begin
         rd_valid_r <= 1'b0;
      end
   end

   logic unused_ok;
   assign unused_ok = &{1'b0, haddr[31:8], hsize, dph_rd_r, dph_ofs_r};
endmodule
`default_nettype wire

// ===== verification/cdr_host.sv
`timescale 1ns/1ps
`default_nettype none
module cdr_host
   import cdr_pkg::*;
(
   input wire logic hclk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      htrans = 2'h0;
   end
   ////////////////////////////////////////
   // one single word transfer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output int n);
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      do xfer(1'b0, CDR_OFS_STATUS, 32'h0, s, n); while (s[8:7] !== 2'h0);
   endtask
   task automatic cmd(input logic [9:0] c);
      logic [31:0] s;
      int n;
      wait_idle();
      xfer(1'b1, CDR_OFS_CMD, {22'h0, c}, s, n);
      repeat (4) @(posedge hclk);
      wait_idle();
   endtask
endmodule
`default_nettype wire

// ===== verification/cdr_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cdr_top_chk
   import cdr_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata
);
   logic ph_v, ph_w, two_r, glyph_r, have_r, rdv_r;
   logic [7:0] ph_a;
   logic [6:0] ac_r;
   logic [10:0] stall_r;
   logic req, rd_st, rd_dat, wr_cmd, idle;
   assign req = hsel && htrans[1] && hready;
   assign rd_st = ph_v && !ph_w && ph_a == CDR_OFS_STATUS && hready;
   assign rd_dat = ph_v && !ph_w && ph_a == CDR_OFS_RDDATA && hready;
   assign wr_cmd = ph_v && ph_w && ph_a == CDR_OFS_CMD && hready;
   assign idle = hrdata[8:7] == 2'h0;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_v <= 1'b0;
         ph_w <= 1'b0;
         ph_a <= 8'h00;
      end else if (hready) begin
         ph_v <= hsel && htrans[1];
         ph_w <= hwrite;
         ph_a <= haddr[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         two_r <= 1'b0;
         glyph_r <= 1'b0;
      end else if (wr_cmd && hwdata[9:8] == 2'h0) begin
         if (hwdata[7] || hwdata[7:3] == 5'h02) glyph_r <= 1'b0;
         if (hwdata[7:6] == 2'h1) glyph_r <= 1'b1;
         if (hwdata[7:5] == 3'h1) two_r <= hwdata[3];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         have_r <= 1'b0;
         ac_r <= 7'h00;
         rdv_r <= 1'b0;
      end else if (wr_cmd) begin
         have_r <= 1'b0;
         rdv_r <= 1'b0;
      end else begin
         if (rd_st && idle) begin
            have_r <= 1'b1;
            ac_r <= hrdata[6:0];
         end
         if (rd_dat) rdv_r <= 1'b1;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) stall_r <= 11'h0;
      else if (hreadyout) stall_r <= 11'h0;
      else stall_r <= stall_r + 11'h1;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_CMD_WAIT: assert property (req && hwrite && haddr[7:0] == CDR_OFS_CMD |=> !hreadyout)
      else $error("command write took no wait state");
   AST_READ_NOWAIT: assert property (req && !hwrite |=> hreadyout)
      else $error("read took a wait state");
   AST_STALL_BOUND: assert property (stall_r <= 11'h44C)
      else $error("command write stalled too long");
   AST_HOLD_RDATA: assert property (!(req && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   AST_STATUS_PAD: assert property (rd_st |-> hrdata[31:10] == 22'h0)
      else $error("status upper bits not zero");
   AST_AC_ONE: assert property (rd_st && idle && !two_r && !glyph_r |-> hrdata[6:0] <= CDR_ONE_LAST)
      else $error("counter outside one-line range");
   AST_AC_TWO: assert property (rd_st && idle && two_r && !glyph_r |->
      hrdata[6:0] <= CDR_L1_LAST || hrdata[6:0] inside {[CDR_L2_FIRST:CDR_L2_LAST]})
      else $error("counter outside two-line ranges");
   AST_GLYPH_RANGE: assert property (rd_st && idle && glyph_r |-> !hrdata[6])
      else $error("glyph counter above six bits");
   AST_AC_STABLE: assert property (rd_st && idle && have_r |-> hrdata[6:0] == ac_r)
      else $error("counter moved without a command");
   AST_RDDATA_CLEAR: assert property (rd_dat && rdv_r |-> !hrdata[8])
      else $error("result valid not cleared by read");
   AST_RESP_OKAY: assert property (!hresp)
      else $error("bus response not okay");
endmodule
bind cdr_top cdr_top_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_top;
   import cdr_pkg::*;
   typedef struct packed {logic [9:0] c; logic [6:0] ac; logic [7:0] d;} cdr_row_t;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int err_count = 0;
   int checked = 0;
   cdr_row_t rows [36] = '{
      {10'h300,7'h01,8'h00}, {10'h0CE,7'h4E,8'h00}, {10'h141,7'h4F,8'h00},
      {10'h142,7'h00,8'h00}, {10'h0CE,7'h4E,8'h00}, {10'h300,7'h4F,8'h41},
      {10'h300,7'h00,8'h42}, {10'h004,7'h00,8'h00}, {10'h080,7'h00,8'h00},
      {10'h143,7'h4F,8'h00}, {10'h0C0,7'h40,8'h00}, {10'h038,7'h40,8'h00},
      {10'h144,7'h27,8'h00}, {10'h006,7'h27,8'h00}, {10'h0A7,7'h27,8'h00},
      {10'h145,7'h40,8'h00}, {10'h0A7,7'h27,8'h00}, {10'h300,7'h40,8'h45},
      {10'h300,7'h41,8'h44}, {10'h07F,7'h3F,8'h00}, {10'h11F,7'h00,8'h00},
      {10'h07F,7'h3F,8'h00}, {10'h300,7'h00,8'h1F}, {10'h080,7'h00,8'h00},
      {10'h300,7'h01,8'h43}, {10'h200,7'h01,8'h01}, {10'h090,7'h10,8'h00},
      {10'h130,7'h11,8'h00}, {10'h148,7'h12,8'h00}, {10'h090,7'h10,8'h00},
      {10'h147,7'h11,8'h00}, {10'h300,7'h12,8'h30}, {10'h080,7'h00,8'h00},
      {10'h146,7'h01,8'h00}, {10'h010,7'h00,8'h00}, {10'h300,7'h01,8'h46}};
   always #20 hclk = ~hclk;
   cdr_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   cdr_top #(.FIFO_DEPTH(CDR_FIFO_DEPTH)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   task automatic give_verdict();
      if (err_count == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (95000) @(posedge hclk);
      err_count++;
      give_verdict();
   end
   ////////////////////////////////////////
   initial begin
      logic [31:0] r;
      int n;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped and read-only places
      host.xfer(1'b0, CDR_OFS_STATUS, 32'h0, r, n);
      `CHK(r, 32'h0)
      host.xfer(1'b0, CDR_OFS_MODE, 32'h0, r, n);
      `CHK(r, 32'h1)
      host.xfer(1'b1, CDR_OFS_STATUS, 32'hFFFF, r, n);
      host.xfer(1'b0, 8'h10, 32'h0, r, n);
      `CHK(r, 32'h0)
      foreach (rows[i]) begin
         host.cmd(rows[i].c);
         host.xfer(1'b0, CDR_OFS_STATUS, 32'h0, r, n);
         `CHK(r[9:0], {rows[i].c[9], 2'h0, rows[i].ac})
         if (rows[i].c[9]) begin
            host.xfer(1'b0, CDR_OFS_RDDATA, 32'h0, r, n);
            `CHK(r[8:0], {1'b1, rows[i].d})
            host.xfer(1'b0, CDR_OFS_RDDATA, 32'h0, r, n);
            `CHK(r[8], 1'b0)
         end
      end
      // second command held back while busy
      host.xfer(1'b1, CDR_OFS_CMD, 32'h80, r, n);
      host.xfer(1'b1, CDR_OFS_CMD, 32'h94, r, n);
      repeat (4) @(posedge hclk);
      host.xfer(1'b0, CDR_OFS_STATUS, 32'h0, r, n);
      `CHK(r[8:7], 2'h3)
      host.wait_idle();
      host.xfer(1'b0, CDR_OFS_STATUS, 32'h0, r, n);
      `CHK(r[7:0], 8'h14)
      // fill the queue until it stalls
      for (int k = 0; k < 18; k++) begin
         host.xfer(1'b1, CDR_OFS_CMD, 32'h06, r, n);
         if (k == 16) `CHK(n < 10, 1'b1)
         if (k == 17) `CHK(n > 100, 1'b1)
      end
      host.wait_idle();
      // display shift on write only
      host.cmd(10'h007);
      host.cmd(10'h0A0);
      host.cmd(10'h150);
      host.xfer(1'b0, CDR_OFS_MODE, 32'h0, r, n);
      `CHK(r, 32'h107)
      host.cmd(10'h0A0);
      host.cmd(10'h300);
      host.xfer(1'b0, CDR_OFS_MODE, 32'h0, r, n);
      `CHK(r, 32'h107)
      host.cmd(10'h005);
      host.cmd(10'h151);
      host.xfer(1'b0, CDR_OFS_MODE, 32'h0, r, n);
      `CHK(r, 32'h6)
      // display shift instruction moves position only
      host.cmd(10'h018);
      host.xfer(1'b0, CDR_OFS_MODE, 32'h0, r, n);
      `CHK(r, 32'h106)
      // reset in mid-run, first read is stale again
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      host.xfer(1'b0, CDR_OFS_MODE, 32'h0, r, n);
      `CHK(r, 32'h1)
      host.cmd(10'h300);
      host.xfer(1'b0, CDR_OFS_RDDATA, 32'h0, r, n);
      `CHK(r[8:0], 9'h100)
      give_verdict();
   end
endmodule
`default_nettype wire
